/* masked_compare_unit.sv */
`timescale 1ns/10ps
//------------------------------------------------------------------
// Masked magnitude and parity comparator
//------------------------------------------------------------------
module masked_compare_unit
	import search_skip_pkg::*;
(
	// Selection
	input wire cmp_mode_e mode_i,
	// Operands
	input wire logic [35:0] word_i,
	input wire logic [35:0] mask_i,
	input wire logic [35:0] ref_i,
	// Result
	output logic cond_o
);

	logic [35:0] product;

	// Logical product feeds both compare and parity
	always_comb begin
		product = word_i & mask_i;
		case (mode_i)
			CMP_LE: cond_o = (product <= ref_i);
			CMP_GT: cond_o = (product > ref_i);
			PAR_EVEN: cond_o = ~^product;
			PAR_ODD: cond_o = ^product;
			default: cond_o = 1'b0;
		endcase
	end

endmodule : masked_compare_unit

/* masked_search_and_skip_tests.sv */
`timescale 1ns/10ps
//------------------------------------------------------------------
// Masked searches and skip tests execution sequencer
//------------------------------------------------------------------
module masked_search_and_skip_tests
	import search_skip_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Instruction issue
	input wire logic start_i,
	input wire logic [5:0] opcode_i,
	input wire logic [3:0] j_field_i,
	input wire logic [3:0] a_field_i,
	input wire logic [3:0] x_field_i,
	input wire logic h_flag_i,
	input wire logic [17:0] u_field_i,
	// Control register values
	input wire logic [17:0] repeat_count_register_i,
	input wire logic [35:0] mask_register_i,
	input wire logic [35:0] operand_register_i,
	input wire logic [35:0] selected_index_register_i,
	input wire logic [35:0] address_index_i,
	// Storage operand port
	output logic mem_req_o,
	output logic [17:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [35:0] mem_data_i,
	// Program address and next instruction
	output logic pc_inc_o,
	output logic next_instruction_fetch_o,
	output logic next_instruction_discard_o,
	// Register write back
	output logic repeat_count_wr_o,
	output logic [17:0] repeat_count_o,
	output logic index_wr_o,
	output logic [3:0] index_sel_o,
	output logic [35:0] index_o,
	// Status
	output logic busy_o,
	output logic done_o,
	output logic skip_o
);

	//------------------------------------------------------------------
	// State
	//------------------------------------------------------------------
	typedef struct packed {
		state_e st;
		logic [5:0] opc;
		logic [3:0] j;
		logic [3:0] a;
		logic [3:0] x;
		logic h;
		logic [17:0] u;
		logic [17:0] cnt;
		logic [35:0] mask;
		logic [35:0] refv;
		logic [35:0] xi;
		logic [35:0] mod;
		logic [35:0] opnd;
		logic skip;
		logic [17:0] addr;
		logic rc_wr;
		logic [17:0] rc_out;
		logic idx_wr;
		logic [3:0] idx_sel;
		logic [35:0] idx_out;
	} state_s;

	state_s q;
	state_s d;
	logic reset_meta_q;
	logic reset_sync_q;
	logic is_search;
	logic is_parity;
	logic is_modifier;
	logic use_index;
	logic immediate;
	logic cond;
	logic mod_skip;
	logic [17:0] ea;
	logic [17:0] cnt_dec;
	logic [17:0] xi_step;
	logic [35:0] cmp_word;
	logic [35:0] cmp_mask;
	cmp_mode_e cmp_mode;

	//------------------------------------------------------------------
	// Reset release
	//------------------------------------------------------------------
	// Two stage release of the asynchronous reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reset_meta_q <= 1'b0;
			reset_sync_q <= 1'b0;
		end else begin
			reset_meta_q <= 1'b1;
			reset_sync_q <= reset_meta_q;
		end
	end

	//------------------------------------------------------------------
	// Decode and datapath
	//------------------------------------------------------------------
	// Instruction class and address formation
	always_comb begin
		is_search = (q.opc == OPC_SEARCH);
		is_parity = (q.opc == OPC_PARITY_EVEN) ||
			(q.opc == OPC_PARITY_ODD);
		is_modifier = (q.opc == OPC_MODIFIER);
		use_index = (q.x != 4'h0);
		immediate = !is_search && ((q.j == J_IMM_A) || (q.j == J_IMM_B));
		ea = index_add(q.u, use_index ? q.xi[17:0] : HALF_ZERO);
		xi_step = index_add(q.xi[17:0], q.xi[35:18]);
		cnt_dec = q.cnt - 18'h00001;
		mod_skip = (q.opnd[17:0] <= q.mod[17:0]);
	end

	// Comparator operand steering
	always_comb begin
		cmp_word = (q.st == ST_FETCH) ? mem_data_i : q.opnd;
		cmp_mask = is_search ? q.mask : q.refv;
		if (is_search) begin
			cmp_mode = (q.j == MINOR_SEARCH_GT) ? CMP_GT : CMP_LE;
		end else begin
			cmp_mode = (q.opc == OPC_PARITY_ODD) ? PAR_ODD : PAR_EVEN;
		end
	end

	masked_compare_unit u_compare (
		.mode_i(cmp_mode),
		.word_i(cmp_word),
		.mask_i(cmp_mask),
		.ref_i(q.refv),
		.cond_o(cond)
	);

	//------------------------------------------------------------------
	// Partial word selection of the fetched operand
	//------------------------------------------------------------------
	function automatic logic [35:0] partial_word(input logic [35:0] w,
		input logic [3:0] jf);
		case (jf)
			J_LOW_HALF: return {HALF_ZERO, w[17:0]};
			J_HIGH_HALF: return {HALF_ZERO, w[35:18]};
			J_LOW_SIGNED: return {{18{w[17]}}, w[17:0]};
			default: return w;
		endcase
	endfunction : partial_word

	//------------------------------------------------------------------
	// Sequencer
	//------------------------------------------------------------------
	// Next state of the whole block
	always_comb begin
		d = q;
		d.rc_wr = 1'b0;
		d.idx_wr = 1'b0;
		case (q.st)
			ST_IDLE: begin
				if (start_i) begin
					d.opc = opcode_i;
					d.j = j_field_i;
					d.a = a_field_i;
					d.x = x_field_i;
					d.h = h_flag_i;
					d.u = u_field_i;
					d.cnt = repeat_count_register_i;
					d.mask = mask_register_i;
					d.xi = address_index_i;
					d.mod = selected_index_register_i;
					d.skip = 1'b0;
					if (opcode_i == OPC_SEARCH) begin
						d.refv = operand_register_i & mask_register_i;
					end else begin
						d.refv = operand_register_i;
					end
					d.st = ST_INIT;
				end
			end
			ST_INIT: begin
				d.addr = ea;
				if (is_search && (q.cnt == HALF_ZERO)) begin
					d.st = ST_NEXT;
				end else if (immediate) begin
					d.opnd = {HALF_ZERO, ea};
					d.st = ST_TERM;
				end else begin
					d.st = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (mem_ack_i) begin
					if (is_search) begin
						d.cnt = cnt_dec;
						if (q.h && use_index) begin
							d.xi = {q.xi[35:18], xi_step};
							d.addr = index_add(q.u, xi_step);
						end
						if (cond) begin
							d.skip = 1'b1;
							d.rc_out = cnt_dec;
							d.st = ST_TERM;
						end else if (cnt_dec == HALF_ZERO) begin
							d.skip = 1'b0;
							d.rc_out = HALF_ZERO;
							d.st = ST_TERM;
						end
					end else begin
						d.opnd = partial_word(mem_data_i, q.j);
						d.st = ST_TERM;
					end
				end
			end
			ST_TERM: begin
				if (is_search) begin
					d.rc_wr = 1'b1;
				end else if (is_parity) begin
					d.skip = cond;
				end else if (is_modifier) begin
					d.skip = mod_skip;
					d.idx_wr = 1'b1;
					d.idx_sel = q.a;
					d.idx_out = {q.mod[35:18],
						index_add(q.mod[17:0], q.mod[35:18])};
				end
				d.st = ST_NEXT;
			end
			ST_NEXT: begin
				// Index increment, dropped when the modifier already wrote it
				if (q.h && use_index &&
					!(is_modifier && (q.a == q.x))) begin
					d.idx_wr = 1'b1;
					d.idx_sel = q.x;
					d.idx_out = is_search ? q.xi : {q.xi[35:18], xi_step};
				end
				d.st = ST_WB;
			end
			ST_WB: begin
				d.st = ST_IDLE;
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i or negedge reset_sync_q) begin
		if (!reset_sync_q) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	//------------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------------
	// Handshakes decoded from state, data from flops
	always_comb begin
		pc_inc_o = (q.st == ST_INIT) ||
			((q.st == ST_NEXT) && q.skip);
		next_instruction_fetch_o = (q.st == ST_NEXT);
		next_instruction_discard_o = (q.st == ST_NEXT) && q.skip;
		mem_req_o = (q.st == ST_FETCH);
		mem_addr_o = q.addr;
		repeat_count_wr_o = q.rc_wr;
		repeat_count_o = q.rc_out;
		index_wr_o = q.idx_wr;
		index_sel_o = q.idx_sel;
		index_o = q.idx_out;
		busy_o = (q.st != ST_IDLE);
		done_o = (q.st == ST_WB);
		skip_o = q.skip;
	end

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_sync_q);

	// A search stage that ends with the condition met
	sequence seq_search_hit;
		(q.st == ST_FETCH) && is_search && mem_ack_i && cond;
	endsequence

	// A search stage that runs out of count
	sequence seq_search_miss;
		(q.st == ST_FETCH) && is_search && mem_ack_i && !cond &&
			(cnt_dec == HALF_ZERO);
	endsequence

	// An accepted instruction
	sequence seq_issue;
		(q.st == ST_IDLE) && start_i;
	endsequence

	AST_INIT_BUMP: assert property (
		seq_issue |=> pc_inc_o && !next_instruction_fetch_o
	) else $error("initial stage did not bump program address");

	AST_ZERO_COUNT: assert property (
		(q.st == ST_INIT) && is_search && (q.cnt == HALF_ZERO)
			|=> next_instruction_fetch_o && !pc_inc_o && !mem_req_o
	) else $error("zero repeat count still ran a test stage");

	AST_DECREMENT: assert property (
		(q.st == ST_FETCH) && is_search && mem_ack_i
			|=> q.cnt == $past(q.cnt) - 18'h00001
	) else $error("search stage did not decrement the count");

	AST_HIT_REMNANT: assert property (
		seq_search_hit |=> ##1 repeat_count_wr_o &&
			(repeat_count_o == $past(cnt_dec, 2)) && pc_inc_o
	) else $error("hit did not store remnant count and skip");

	AST_MISS_ZERO: assert property (
		seq_search_miss |=> ##1 repeat_count_wr_o &&
			(repeat_count_o == HALF_ZERO) && !pc_inc_o
	) else $error("exhausted search did not store zero without skip");

	AST_ADDR_STEP: assert property (
		(q.st == ST_FETCH) && is_search && mem_ack_i && q.h &&
			use_index && (q.xi[35:18] != HALF_ZERO) &&
			(q.xi[35:18] != HALF_ONES) && !cond &&
			(cnt_dec != HALF_ZERO)
			|=> mem_req_o && (mem_addr_o != $past(mem_addr_o))
	) else $error("search stage reused the same address");

	AST_SKIP_DISCARD: assert property (
		next_instruction_fetch_o |-> (pc_inc_o == skip_o) &&
			(next_instruction_discard_o == skip_o) ##1 done_o
	) else $error("skip did not discard and bump a second time");

	AST_PARITY_NO_SAVE: assert property (
		(q.st == ST_TERM) && is_parity
			|=> !repeat_count_wr_o && !index_wr_o
	) else $error("parity test wrote a result");

	AST_MODIFIER_SUM: assert property (
		(q.st == ST_TERM) && is_modifier |=> index_wr_o &&
			(index_o[35:18] == $past(q.mod[35:18])) &&
			(index_sel_o == $past(q.a))
	) else $error("modifier did not keep upper half");

	AST_MODIFIER_ONCE: assert property (
		(q.st == ST_NEXT) && is_modifier && (q.a == q.x)
			|=> !index_wr_o
	) else $error("same index register written twice");

	AST_MODIFIER_SKIP: assert property (
		(q.st == ST_TERM) && is_modifier
			|=> (skip_o == ($past(q.opnd[17:0]) <= $past(q.mod[17:0])))
	) else $error("modifier skip decision wrong");

endmodule : masked_search_and_skip_tests

/* search_skip_pkg.sv */
//------------------------------------------------------------------
// Constants for masked search and skip test execution
//------------------------------------------------------------------
// Contract
// - Search-le ends when masked word not above
// - Initial stage loads count, masks operand, bumps P
// - Zero count: no test, go to next
// - Each stage decrements count, fetches storage word
// - Hit stores remnant count and skips next
// - Miss at zero stores zero, no skip
// - Search-gt ends with skip when word greater
// - All-ones ranks above all-zeros in search
// - Incrementing index gives new address each stage
// - Next instruction always fetched; skip discards it
// - All zeros positive zero, all ones negative
// - Even parity of AND product skips next
// - Odd parity of AND product skips next
// - Parity product never written anywhere
// - Index adder yields positive zero, used as operand
// - Parity operand undefined when fields collide
// - Modifier test skips when index low not below
// - Modifier always adds upper half into lower
// - Modifier halves compared as unsigned magnitudes
// - Field codes 0,1,3 alike; 16,17 alike
// - Same index register modified exactly once
package search_skip_pkg;

	//------------------------------------------------------------------
	// Widths and word constants
	//------------------------------------------------------------------
	localparam int WORD_W = 36;
	localparam int HALF_W = 18;
	localparam logic [17:0] HALF_ONES = 18'h3ffff; // Negative zero half
	localparam logic [17:0] HALF_ZERO = 18'h00000; // Positive zero half

	//------------------------------------------------------------------
	// Operation codes and field codes
	//------------------------------------------------------------------
	localparam logic [5:0] OPC_PARITY_EVEN = 6'h24; // Octal 44
	localparam logic [5:0] OPC_PARITY_ODD = 6'h25; // Octal 45
	localparam logic [5:0] OPC_MODIFIER = 6'h27; // Octal 47
	localparam logic [5:0] OPC_SEARCH = 6'h39; // Octal 71
	localparam logic [3:0] MINOR_SEARCH_LE = 4'h6;
	localparam logic [3:0] MINOR_SEARCH_GT = 4'h7;
	localparam logic [3:0] J_FULL = 4'h0;
	localparam logic [3:0] J_LOW_HALF = 4'h1;
	localparam logic [3:0] J_HIGH_HALF = 4'h2;
	localparam logic [3:0] J_LOW_SIGNED = 4'h3;
	localparam logic [3:0] J_IMM_A = 4'he; // Octal 16
	localparam logic [3:0] J_IMM_B = 4'hf; // Octal 17

	//------------------------------------------------------------------
	// Comparator modes and sequencer states
	//------------------------------------------------------------------
	typedef enum logic [1:0] {
		CMP_LE = 2'h0,
		CMP_GT = 2'h1,
		PAR_EVEN = 2'h2,
		PAR_ODD = 2'h3
	} cmp_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_INIT = 3'h1,
		ST_FETCH = 3'h3,
		ST_TERM = 3'h2,
		ST_NEXT = 3'h6,
		ST_WB = 3'h7
	} state_e;

	//------------------------------------------------------------------
	// Index adder: ones-complement sum that never yields negative zero
	//------------------------------------------------------------------
	function automatic logic [17:0] index_add(input logic [17:0] p,
		input logic [17:0] q);
		logic [18:0] s;
		logic [17:0] r;
		s = {1'b0, p} + {1'b0, q};
		r = s[17:0] + {17'h00000, s[18]};
		if (r == HALF_ONES) begin
			r = HALF_ZERO;
		end
		return r;
	endfunction : index_add

endpackage : search_skip_pkg

/* tb.sv */
`timescale 1ns/10ps
module tb;
	import search_skip_pkg::*;

	//------------------------------------------------------------------
	// Design connections
	//------------------------------------------------------------------
	logic clk_i, reset_n_i, start_i, h_flag_i, mem_ack_i;
	logic [5:0] opcode_i;
	logic [3:0] j_field_i, a_field_i, x_field_i, index_sel_o;
	logic [17:0] u_field_i, repeat_count_register_i, mem_addr_o;
	logic [17:0] repeat_count_o;
	logic [35:0] mask_register_i, operand_register_i, mem_data_i;
	logic [35:0] selected_index_register_i, address_index_i, index_o;
	logic mem_req_o, pc_inc_o, next_instruction_fetch_o;
	logic next_instruction_discard_o, repeat_count_wr_o, index_wr_o;
	logic busy_o, done_o, skip_o;

	//------------------------------------------------------------------
	// Bench state
	//------------------------------------------------------------------
	int fail_count, n_checks, cycles;
	int n_pc, n_fetch, n_disc, n_nif, n_rcw, n_ixw;
	logic got_skip;
	logic [17:0] rc_val;
	logic [35:0] ix_val;
	logic [3:0] ix_sel;
	logic [17:0] addr_q[$];
	logic [35:0] mem_words[0:3];

	masked_search_and_skip_tests i_masked_search_and_skip_tests (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i),
		.opcode_i(opcode_i), .j_field_i(j_field_i),
		.a_field_i(a_field_i), .x_field_i(x_field_i),
		.h_flag_i(h_flag_i), .u_field_i(u_field_i),
		.repeat_count_register_i(repeat_count_register_i),
		.mask_register_i(mask_register_i),
		.operand_register_i(operand_register_i),
		.selected_index_register_i(selected_index_register_i),
		.address_index_i(address_index_i),
		.mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
		.mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i),
		.pc_inc_o(pc_inc_o),
		.next_instruction_fetch_o(next_instruction_fetch_o),
		.next_instruction_discard_o(next_instruction_discard_o),
		.repeat_count_wr_o(repeat_count_wr_o),
		.repeat_count_o(repeat_count_o), .index_wr_o(index_wr_o),
		.index_sel_o(index_sel_o), .index_o(index_o),
		.busy_o(busy_o), .done_o(done_o), .skip_o(skip_o)
	);

	//------------------------------------------------------------------
	// Clock and hang guard
	//------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			conclude();
		end
	end

	//------------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------------
	// Compare and count
	task automatic check(input string name, input logic [35:0] seen,
		input logic [35:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Issue one instruction, answer storage, log outputs until done
	task automatic run(input logic [5:0] op, input logic [3:0] j, a, x,
		input logic h, input logic [17:0] u, cnt, input logic [35:0] xr);
		@(negedge clk_i);
		opcode_i = op;
		j_field_i = j;
		a_field_i = a;
		x_field_i = x;
		h_flag_i = h;
		u_field_i = u;
		repeat_count_register_i = cnt;
		selected_index_register_i = xr;
		address_index_i = xr;
		start_i = 1'b1;
		{n_pc, n_fetch, n_disc, n_nif, n_rcw, n_ixw} = '0;
		got_skip = 1'b0;
		addr_q.delete();
		for (int i = 0; i < 60; i++) begin
			@(negedge clk_i);
			start_i = 1'b0;
			n_pc += (pc_inc_o === 1'b1);
			n_disc += (next_instruction_discard_o === 1'b1);
			n_nif += (next_instruction_fetch_o === 1'b1);
			if (repeat_count_wr_o === 1'b1) begin
				n_rcw++;
				rc_val = repeat_count_o;
			end
			if (index_wr_o === 1'b1) begin
				n_ixw++;
				ix_val = index_o;
				ix_sel = index_sel_o;
			end
			// Storage answers at once; idle data keeps toggling
			if (mem_req_o === 1'b1) begin
				addr_q.push_back(mem_addr_o);
				mem_ack_i = 1'b1;
				mem_data_i = mem_words[n_fetch % 4];
				n_fetch++;
			end else begin
				mem_ack_i = 1'b0;
				mem_data_i = ~mem_data_i;
			end
			if (done_o === 1'b1) begin
				got_skip = skip_o;
				check("busy", {35'h0, busy_o}, 36'h1);
				break;
			end
		end
		check("done", {35'h0, done_o}, 36'h1);
	endtask : run

	//------------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------------
	// Masked search less-or-equal, hit on second stage with indexing
	task automatic test_search_le;
		mask_register_i = 36'h0_ffff_ffff;
		operand_register_i = 36'h0_0000_1000;
		mem_words = '{36'hf_0000_2000, 36'hf_0000_1000, 36'h0, 36'h0};
		// Operand and index fields kept apart
		run(OPC_SEARCH, MINOR_SEARCH_LE, 4'h0, 4'h1, 1'b1, 18'h00100,
			18'h00003, {18'h00002, 18'h00010});
		check("stages", 36'(n_fetch), 36'd2);
		check("skip", {35'h0, got_skip}, 36'h1);
		check("remnant", {18'h0, rc_val}, 36'h1);
		check("rc writes", 36'(n_rcw), 36'd1);
		check("pc bumps", 36'(n_pc), 36'd2);
		check("discards", 36'(n_disc), 36'd1);
		check("ni fetches", 36'(n_nif), 36'd1);
		check("addr 1", {18'h0, addr_q[0]}, 36'h110);
		check("addr 2", {18'h0, addr_q[1]}, 36'h112);
		check("index", ix_val, {18'h00002, 18'h00014});
		$display("search le test done");
	endtask : test_search_le

	// Masked search greater: full miss, then all-ones above zero
	task automatic test_search_gt;
		mask_register_i = 36'hf_ffff_ffff;
		operand_register_i = 36'hf_ffff_ffff;
		mem_words = '{36'h0, 36'h7_ffff_ffff, 36'h0, 36'h0};
		run(OPC_SEARCH, MINOR_SEARCH_GT, 4'h0, 4'h0, 1'b0, 18'h00050,
			18'h00002, 36'h0);
		check("stages", 36'(n_fetch), 36'd2);
		check("skip", {35'h0, got_skip}, 36'h0);
		check("remnant", {18'h0, rc_val}, 36'h0);
		check("pc bumps", 36'(n_pc), 36'd1);
		check("discards", 36'(n_disc), 36'd0);
		check("addr 2", {18'h0, addr_q[1]}, 36'h050);
		operand_register_i = 36'h0;
		mem_words[0] = 36'hf_ffff_ffff;
		run(OPC_SEARCH, MINOR_SEARCH_GT, 4'h0, 4'h0, 1'b0, 18'h00050,
			18'h00005, 36'h0);
		check("stages", 36'(n_fetch), 36'd1);
		check("skip", {35'h0, got_skip}, 36'h1);
		check("remnant", {18'h0, rc_val}, 36'h4);
		$display("search gt test done");
	endtask : test_search_gt

	// Zero repeat count goes straight on
	task automatic test_zero_count;
		run(OPC_SEARCH, MINOR_SEARCH_LE, 4'h0, 4'h0, 1'b0, 18'h00050,
			18'h00000, 36'h0);
		check("stages", 36'(n_fetch), 36'd0);
		check("rc writes", 36'(n_rcw), 36'd0);
		check("skip", {35'h0, got_skip}, 36'h0);
		check("pc bumps", 36'(n_pc), 36'd1);
		check("ni fetches", 36'(n_nif), 36'd1);
		$display("zero count test done");
	endtask : test_zero_count

	// Even and odd parity of the logical product
	task automatic test_parity;
		logic odd;
		logic exp;
		operand_register_i = 36'h0_0000_000f;
		for (int k = 0; k < 4; k++) begin
			odd = k[0];
			exp = k[1] ? odd : ~odd;
			mem_words[0] = odd ? 36'h8_0000_0007 : 36'h8_0000_0003;
			run(k[1] ? OPC_PARITY_ODD : OPC_PARITY_EVEN, J_FULL, 4'h3,
				4'h0, 1'b0, 18'h00040, 18'h0, 36'h0);
			check("skip", {35'h0, got_skip}, {35'h0, exp});
			check("rc writes", 36'(n_rcw), 36'd0);
			check("ix writes", 36'(n_ixw), 36'd0);
			check("pc bumps", 36'(n_pc), 36'(1 + exp));
			check("discards", 36'(n_disc), {35'h0, exp});
		end
		$display("parity test done");
	endtask : test_parity

	// Modifier test over field codes, immediate zero and a equal x
	task automatic test_modifier;
		logic [3:0] jt[0:4] = '{4'h0, 4'h1, 4'h3, 4'he, 4'h0};
		logic [35:0] wt[0:4] = '{36'hf_fffc_0100, 36'h0_0000_0101,
			36'h0_0003_ffff, 36'h0, 36'h0};
		logic [4:0] sk = 5'b11001;
		for (int k = 0; k < 5; k++) begin
			mem_words[0] = wt[k];
			run(OPC_MODIFIER, jt[k], (k == 4) ? 4'h2 : 4'h5,
				(k == 4) ? 4'h2 : 4'h0, k >= 3,
				(k == 3) ? 18'h3ffff : 18'h00200, 18'h0,
				{18'h00003, 18'h00100});
			check("skip", {35'h0, got_skip}, {35'h0, sk[k]});
			check("pc bumps", 36'(n_pc), 36'(1 + sk[k]));
			check("ix writes", 36'(n_ixw), 36'd1);
			if (k < 4) begin
				check("index", ix_val, {18'h00003, 18'h00103});
				check("index sel", {32'h0, ix_sel}, 36'h5);
			end
		end
		$display("modifier test done");
	endtask : test_modifier

	// Counts and verdict
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	//------------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------------
	initial begin
		{start_i, h_flag_i, mem_ack_i, opcode_i, j_field_i} = '0;
		{a_field_i, x_field_i, u_field_i, repeat_count_register_i} = '0;
		{mask_register_i, operand_register_i, mem_data_i} = '0;
		{selected_index_register_i, address_index_i} = '0;
		reset_n_i = 1'b0;
		repeat (10) @(negedge clk_i);
		reset_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		test_search_le();
		test_search_gt();
		test_zero_count();
		test_parity();
		test_modifier();
		conclude();
	end

endmodule : tb
